// file: hdl/gauge_cmd_defines.vh
// constants for the gauge mode and alarm command registers
`ifndef GAUGE_CMD_DEFINES_VH
`define GAUGE_CMD_DEFINES_VH
// bus addresses (7-bit)
`define SLAVE_ADDR        7'h0B
`define HOST_ADDR         7'h10
`define CHARGER_ADDR      7'h12
// command codes
`define CMD_VENDOR        8'h00
`define CMD_LOW_CAP       8'h01
`define CMD_LOW_TIME      8'h02
`define CMD_PACK_MODE     8'h03
`define CMD_CHARGE_LEFT   8'h0F
// vendor command values
`define VC_DEV_TYPE       16'h0001
`define VC_FW_REV         16'h0002
`define VC_EDV_LEVEL      16'h0003
`define VC_SEAL           16'h062B
// pack mode bit positions and write mask
`define PM_RELEARN        7
`define PM_CHG_CTRL       8
`define PM_PRIMARY        9
`define PM_ALARM_OFF      13
`define PM_CHARGER_OFF    14
`define PM_CAP_UNITS      15
`define PM_WRITE_MASK     16'hE000
// reset values
`define PM_RESET          16'h0080
`define THR_RESET         16'h0000
// relearn after this many cycle counts without full charge update
`define RELEARN_CYCLES    5'h14
// alarm-off hold time
`define ALARM_HOLD_S      36'h00000003C
`define CLK_HZ            36'h00BEBC200
`endif

// file: hdl/gauge_mode_and_alarm_commands.v
// gauge command registers 0x00-0x03 with their serial slave port
`timescale 1ns/10ps
`include "gauge_cmd_defines.vh"

module gauge_mode_and_alarm_commands #(
  parameter [15:0] DEVICE_TYPE       = 16'hA5A5, // arbitrary value
  parameter [35:0] ALARM_HOLD_CYCLES = `ALARM_HOLD_S * `CLK_HZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // serial bus pins, open drain
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  // gauge core values
  input  wire [15:0] charge_left,
  input  wire [15:0] avg_runtime_left,
  input  wire [15:0] fw_revision,
  input  wire [15:0] edv_level,
  // config flash image and nonvolatile seal
  input  wire        flash_load,
  input  wire [15:0] flash_low_cap,
  input  wire [15:0] flash_low_time,
  input  wire        sealed_nv,
  output reg         seal_store,
  // learning events
  input  wire        full_reset,
  input  wire        cycle_count_tick,
  input  wire        full_charge_update,
  input  wire        learn_done,
  input  wire        sleep_enter,
  // mode and status outputs
  output wire        sealed,
  output wire        cal_allow,
  output wire        flash_allow,
  output reg         charge_left_wr,
  output reg  [15:0] charge_left_data,
  output wire        cap_units_10mw,
  output wire        charger_bcast_en,
  output wire        alarm_bcast_en,
  output reg         low_cap_alarm,
  output reg         low_time_alarm,
  output wire        alarm_msg_req,
  output wire [6:0]  alarm_dest_addr
);

  localparam [2:0] P_ADDR = 3'h0;
  localparam [2:0] P_CMD  = 3'h1;
  localparam [2:0] P_WLO  = 3'h2;
  localparam [2:0] P_WHI  = 3'h3;
  localparam [2:0] P_RLO  = 3'h4;
  localparam [2:0] P_RHI  = 3'h5;
  localparam [2:0] P_IGN  = 3'h6;

  // ==========================================================
  // pin synchronisers and edge detection
  reg  [2:0]  scl_s;
  reg  [2:0]  sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  // third stage only feeds edge compare, first stage read by second alone
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      {scl_s, sda_s} <= 6'h3F; // idle high, so no false start after reset
    else
      {scl_s, sda_s} <= {scl_s[1:0], scl_in, sda_s[1:0], sda_in};
  end
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign bus_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // ==========================================================
  // register state
  reg  [15:0] vendor_command_word;
  reg  [15:0] low_capacity_threshold;
  reg  [15:0] low_runtime_threshold;
  reg  [15:0] pack_mode_word;
  reg         seal_set;
  reg  [4:0]  relearn_count;
  reg  [35:0] hold_count;

  // ==========================================================
  // byte engine
  reg  [2:0]  phase;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  cmd;
  reg  [7:0]  wr_lo;
  reg  [15:0] rd_word;
  reg         drive_low;
  reg         wr_stb;
  reg  [15:0] wr_data;
  wire        ack_ok;
  wire [7:0]  tx_byte;
  // read mux, used at address time
  function [15:0] read_word;
    input [7:0] code;
    begin
      case (code)
        `CMD_VENDOR:      read_word = vendor_command_word;
        `CMD_LOW_CAP:     read_word = low_capacity_threshold;
        `CMD_LOW_TIME:    read_word = low_runtime_threshold;
        `CMD_PACK_MODE:   read_word = pack_mode_word;
        `CMD_CHARGE_LEFT: read_word = charge_left;
        default:          read_word = 16'h0000;
      endcase
    end
  endfunction

  assign ack_ok  = (phase == P_ADDR) ? (shreg[7:1] == `SLAVE_ADDR) :
                   ((phase == P_CMD) | (phase == P_WLO) | (phase == P_WHI));
  assign tx_byte = (phase == P_RLO) ? rd_word[7:0] : rd_word[15:8];
  // bit counter counts rises; ninth rise is the acknowledge slot
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase               <= P_IGN;
      bit_cnt             <= 4'h0;
      {shreg, cmd, wr_lo} <= 24'h000000;
      {rd_word, wr_data}  <= 32'h00000000;
      {drive_low, wr_stb} <= 2'h0;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (bus_start)
      begin
        phase     <= P_ADDR;
        bit_cnt   <= 4'h0;
        drive_low <= 1'b0;
      end
      else if (bus_stop)
      begin
        phase     <= P_IGN;
        drive_low <= 1'b0;
      end
      else if (scl_rise && phase != P_IGN)
      begin
        if (bit_cnt < 4'h8)
        begin
          shreg   <= {shreg[6:0], sda_s[1]};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else
        begin
          bit_cnt <= 4'h0;
          case (phase)
            P_ADDR:
            begin
              if (!ack_ok)
                phase <= P_IGN;
              else if (shreg[0])
              begin
                phase   <= P_RLO;
                rd_word <= read_word(cmd);
              end
              else
                phase <= P_CMD;
            end
            P_CMD:
            begin
              cmd   <= shreg;
              phase <= P_WLO;
            end
            P_WLO:
            begin
              wr_lo <= shreg;
              phase <= P_WHI;
            end
            P_WHI:
            begin
              wr_data <= {shreg, wr_lo}; // low byte first on the wire
              wr_stb  <= 1'b1;
              phase   <= P_IGN;
            end
            P_RLO:   phase <= sda_s[1] ? P_IGN : P_RHI; // master nack ends read
            default: phase <= P_IGN;
          endcase
        end
      end
      else if (scl_fall)
      begin
        if (bit_cnt == 4'h8)
          drive_low <= ack_ok;
        else if ((phase == P_RLO || phase == P_RHI) && bit_cnt < 4'h8)
          drive_low <= ~tx_byte[3'h7 - bit_cnt[2:0]];
        else
          drive_low <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  // ==========================================================
  // register writes and hardware updates
  wire wr_vendor = wr_stb & (cmd == `CMD_VENDOR);
  wire wr_mode   = wr_stb & (cmd == `CMD_PACK_MODE);
  wire hold_done = (hold_count == 36'h000000001);
  wire relearn_hit = cycle_count_tick & ~full_charge_update &
                     (relearn_count == `RELEARN_CYCLES - 5'h01);
  assign sealed      = sealed_nv | seal_set;
  assign cal_allow   = ~sealed;
  assign flash_allow = ~sealed;

  // vendor word, seal, threshold and protected writes
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vendor_command_word    <= 16'h0000;
      {seal_set, seal_store} <= 2'h0;
      low_capacity_threshold <= `THR_RESET;
      low_runtime_threshold  <= `THR_RESET;
      charge_left_wr         <= 1'b0;
      charge_left_data       <= 16'h0000;
    end
    else
    begin
      seal_store     <= 1'b0;
      charge_left_wr <= 1'b0;
      if (wr_vendor)
      begin
        // query result stays until the next vendor write
        case (wr_data)
          `VC_DEV_TYPE:  vendor_command_word <= DEVICE_TYPE;
          `VC_FW_REV:    vendor_command_word <= fw_revision;
          `VC_EDV_LEVEL: vendor_command_word <= edv_level;
          `VC_SEAL:
          begin
            vendor_command_word <= 16'h0000;
            seal_set            <= 1'b1;
            seal_store          <= 1'b1;
          end
          default:       vendor_command_word <= wr_data;
        endcase
      end
      // flash image at init; a host write in the same cycle wins
      if (wr_stb && cmd == `CMD_LOW_CAP)
        low_capacity_threshold <= wr_data;
      else if (flash_load)
        low_capacity_threshold <= flash_low_cap;
      if (wr_stb && cmd == `CMD_LOW_TIME)
        low_runtime_threshold <= wr_data;
      else if (flash_load)
        low_runtime_threshold <= flash_low_time;
      if (wr_stb && cmd == `CMD_CHARGE_LEFT && !sealed)
      begin
        charge_left_wr   <= 1'b1;
        charge_left_data <= wr_data;
      end
    end
  end

  // pack mode word, relearn counting and alarm-off hold timer
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      {pack_mode_word, relearn_count, hold_count} <= {`PM_RESET, 5'h00, 36'h000000000};
    else
    begin
      // only bits 13-15 are kept; 0-6, 8-12 stay zero
      if (wr_mode)
        pack_mode_word[15:13] <= wr_data[15:13];
      else if (sleep_enter)
        pack_mode_word[15:13] <= 3'h0;
      else if (hold_done)
        pack_mode_word[`PM_ALARM_OFF] <= 1'b0;
      if (wr_mode)
        hold_count <= ALARM_HOLD_CYCLES;
      else if (hold_count != 36'h000000000)
        hold_count <= hold_count - 36'h000000001;
      // setting beats clearing on the relearn flag
      if (full_reset || relearn_hit)
        pack_mode_word[`PM_RELEARN] <= 1'b1;
      else if (learn_done)
        pack_mode_word[`PM_RELEARN] <= 1'b0;
      if (full_charge_update || full_reset || relearn_hit)
        relearn_count <= 5'h00;
      else if (cycle_count_tick)
        relearn_count <= relearn_count + 5'h01;
    end
  end

  // ==========================================================
  // alarm evaluation; comparisons are unit-free, core rescales
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      {low_cap_alarm, low_time_alarm} <= 2'h0;
    else
    begin
      low_cap_alarm  <= (low_capacity_threshold != 16'h0000) &&
                        (charge_left < low_capacity_threshold);
      low_time_alarm <= (low_runtime_threshold != 16'h0000) &&
                        (avg_runtime_left < low_runtime_threshold);
    end
  end
  assign cap_units_10mw   = pack_mode_word[`PM_CAP_UNITS];
  assign charger_bcast_en = ~pack_mode_word[`PM_CHARGER_OFF];
  assign alarm_bcast_en   = ~pack_mode_word[`PM_ALARM_OFF];
  // master engine sends write word to this address
  assign alarm_msg_req    = alarm_bcast_en & (low_cap_alarm | low_time_alarm);
  assign alarm_dest_addr  = `HOST_ADDR;

endmodule // gauge_mode_and_alarm_commands

// file: verification/gauge_cmd_checker.sv
// assertions on the gauge command register ports
`timescale 1ns/10ps
module gauge_cmd_checker #(
  parameter [35:0] ALARM_HOLD_CYCLES = 36'h0000000C8
) (
  // clock and reset
  input logic        clk,
  input logic        arst_n,
  // bus clock and core inputs
  input logic        scl_in,
  input logic [15:0] charge_left,
  input logic [15:0] avg_runtime_left,
  input logic        sealed_nv,
  input logic        sleep_enter,
  // design outputs
  input logic        seal_store,
  input logic        sealed,
  input logic        cal_allow,
  input logic        flash_allow,
  input logic        charge_left_wr,
  input logic        cap_units_10mw,
  input logic        charger_bcast_en,
  input logic        alarm_bcast_en,
  input logic        low_cap_alarm,
  input logic        low_time_alarm,
  input logic        alarm_msg_req,
  input logic [6:0]  alarm_dest_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // quiet-time counter
  // bus activity clears it, since a rewrite may legally restart the hold
  logic [35:0] off_cnt;
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      off_cnt <= 36'h000000000;
    else if (alarm_bcast_en || !scl_in)
      off_cnt <= 36'h000000000;
    else
      off_cnt <= off_cnt + 36'h000000001;
  // ==========================================
  // properties
  dest_addr_a: assert property (alarm_dest_addr == 7'h10)
    else $error("alarm destination is not the host");
  alarm_req_a: assert property (alarm_msg_req == (alarm_bcast_en && (low_cap_alarm || low_time_alarm)))
    else $error("alarm request disagrees with enable and alarms");
  cap_top_a: assert property ((charge_left == 16'hFFFF) |=> !low_cap_alarm)
    else $error("capacity alarm with charge at top of range");
  time_top_a: assert property ((avg_runtime_left == 16'hFFFF) |=> !low_time_alarm)
    else $error("runtime alarm with runtime at top of range");
  allow_flags_a: assert property (cal_allow == !sealed && flash_allow == !sealed)
    else $error("calibration or flash access while locked");
  seal_keep_a: assert property (sealed_nv |-> sealed)
    else $error("stored lock not honoured");
  seal_done_a: assert property (seal_store |-> ##[0:2] sealed)
    else $error("lock command did not lock");
  locked_wr_a: assert property (sealed |-> !charge_left_wr)
    else $error("protected write passed while locked");
  wr_pulse_a: assert property (charge_left_wr |=> !charge_left_wr)
    else $error("charge write strobe longer than one cycle");
  sleep_clr_a: assert property (sleep_enter |-> ##[1:2] (alarm_bcast_en && charger_bcast_en && !cap_units_10mw))
    else $error("sleep did not restore mode defaults");
  hold_max_a: assert property (off_cnt <= ALARM_HOLD_CYCLES + 36'h000000004)
    else $error("alarm broadcasts stayed off past the hold time");
endmodule // gauge_cmd_checker

bind gauge_mode_and_alarm_commands gauge_cmd_checker #(
  .ALARM_HOLD_CYCLES(ALARM_HOLD_CYCLES)
) chk (
  .clk              (clk),
  .arst_n           (arst_n),
  .scl_in           (scl_in),
  .charge_left      (charge_left),
  .avg_runtime_left (avg_runtime_left),
  .sealed_nv        (sealed_nv),
  .sleep_enter      (sleep_enter),
  .seal_store       (seal_store),
  .sealed           (sealed),
  .cal_allow        (cal_allow),
  .flash_allow      (flash_allow),
  .charge_left_wr   (charge_left_wr),
  .cap_units_10mw   (cap_units_10mw),
  .charger_bcast_en (charger_bcast_en),
  .alarm_bcast_en   (alarm_bcast_en),
  .low_cap_alarm    (low_cap_alarm),
  .low_time_alarm   (low_time_alarm),
  .alarm_msg_req    (alarm_msg_req),
  .alarm_dest_addr  (alarm_dest_addr)
);

// file: verification/gauge_mode_and_alarm_commands_tb_top.sv
// self-checking bench for the gauge mode and alarm command registers
`timescale 1ns/10ps
`include "gauge_cmd_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module gauge_mode_and_alarm_commands_tb_top;
  localparam int          HOLD = 2000; // outlasts a full read-back of the mode word
  localparam logic [15:0] DEV  = 16'hA5A5; // arbitrary type code
  logic clk, arst_n, scl_in, sda_in, sda_m, sda_out, sda_oe, flash_load, sealed_nv, seal_store;
  logic full_reset, cycle_count_tick, full_charge_update, learn_done, sleep_enter, sealed;
  logic cal_allow, flash_allow, charge_left_wr, cap_units_10mw, charger_bcast_en;
  logic alarm_bcast_en, low_cap_alarm, low_time_alarm, alarm_msg_req;
  logic [15:0] charge_left, avg_runtime_left, fw_revision, edv_level, charge_left_data;
  logic [15:0] flash_low_cap, flash_low_time, rd, seen;
  logic [6:0]  alarm_dest_addr;
  int          error_cnt, n_compared, wr_cnt;
  typedef struct {logic [7:0] c; logic [15:0] d; logic [15:0] e;} row_t;
  row_t rows [9] = '{'{8'h00, 16'h0001, DEV}, '{8'h00, 16'h0002, 16'h1234},
    '{8'h00, 16'h0003, 16'h0BB8}, '{8'h00, 16'h5A5A, 16'h5A5A}, '{8'h01, 16'hFFFF, 16'hFFFF},
    '{8'h02, 16'h0001, 16'h0001}, '{8'h03, 16'hFFFF, 16'hE080}, '{8'h03, 16'h0000, 16'h0080},
    '{8'h3F, 16'hBEEF, 16'h0000}};
  // wire-and of host and device on the data line
  assign sda_in = sda_m & (sda_out | ~sda_oe);
  gauge_mode_and_alarm_commands #(.DEVICE_TYPE(DEV), .ALARM_HOLD_CYCLES(HOLD)) dut (.*);
  smbus_host_model host (.clk(clk), .sda_w(sda_in), .scl_m(scl_in), .sda_m(sda_m));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // outside lock store and charge-write capture
  always @(posedge clk)
  begin
    if (seal_store) sealed_nv <= 1'b1;
    if (charge_left_wr) begin seen <= charge_left_data; wr_cnt <= wr_cnt + 1; end
  end
  task wr(input logic [7:0] c, input logic [15:0] d);
    host.wr_word(`SLAVE_ADDR, c, d);
    `CHK(host.ok, 1'b1)
  endtask
  task rc(input logic [7:0] c, input logic [15:0] e);
    host.rd_word(c, rd);
    `CHK(host.ok, 1'b1)
    `CHK(rd, e)
  endtask
  task ticks(input int n);
    repeat (n) begin @(posedge clk) cycle_count_tick <= 1'b1; @(posedge clk) cycle_count_tick <= 1'b0; end
  endtask
  task wrap_up;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    {arst_n, flash_load, sealed_nv, full_reset, cycle_count_tick, full_charge_update} = 6'h00;
    {learn_done, sleep_enter, wr_cnt, seen} = 0;
    {charge_left, avg_runtime_left} = 32'hFFFFFFFF;
    {fw_revision, edv_level, flash_low_cap, flash_low_time} = 64'h12340BB801000050;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // ordinary rows: write a word, then read back what the rules leave there
    foreach (rows[i])
    begin
      wr(rows[i].c, rows[i].d);
      rc(rows[i].c, rows[i].e);
    end
    flash_load <= 1'b1;
    @(posedge clk) flash_load <= 1'b0;
    rc(8'h01, 16'h0100);
    rc(8'h02, 16'h0050);
    {charge_left, avg_runtime_left} <= 32'h00FF004F;
    repeat (3) @(posedge clk);
    `CHK(low_cap_alarm, 1'b1)
    `CHK(low_time_alarm, 1'b1)
    `CHK(alarm_msg_req, 1'b1)
    // equal to threshold is not below it
    charge_left <= 16'h0100;
    repeat (3) @(posedge clk);
    `CHK(low_cap_alarm, 1'b0)
    charge_left <= 16'h00FF;
    wr(8'h01, 16'h0000);
    wr(8'h02, 16'h0000);
    `CHK(low_cap_alarm, 1'b0)
    `CHK(low_time_alarm, 1'b0)
    wr(8'h03, 16'h2000);
    `CHK(alarm_bcast_en, 1'b0)
    repeat (HOLD) @(posedge clk);
    `CHK(alarm_bcast_en, 1'b1)
    wr(8'h03, 16'hC000);
    `CHK(charger_bcast_en, 1'b0)
    `CHK(cap_units_10mw, 1'b1)
    sleep_enter <= 1'b1;
    @(posedge clk) sleep_enter <= 1'b0;
    learn_done <= 1'b1;
    @(posedge clk) learn_done <= 1'b0;
    rc(8'h03, 16'h0000);
    full_reset <= 1'b1;
    @(posedge clk) full_reset <= 1'b0;
    rc(8'h03, 16'h0080);
    learn_done <= 1'b1;
    @(posedge clk) learn_done <= 1'b0;
    ticks(19);
    rc(8'h03, 16'h0000);
    ticks(1);
    rc(8'h03, 16'h0080);
    wr(8'h0F, 16'h0321);
    `CHK(seen, 16'h0321)
    wr(8'h00, `VC_SEAL);
    `CHK(sealed, 1'b1)
    `CHK(flash_allow, 1'b0)
    rc(8'h00, 16'h0000);
    wr(8'h0F, 16'h0456);
    `CHK(wr_cnt, 1)
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(sealed, 1'b1)
    `CHK(cal_allow, 1'b0)
    wrap_up;
  end
endmodule // gauge_mode_and_alarm_commands_tb_top

// file: verification/smbus_host_model.sv
// bus master model standing in for the system host
`timescale 1ns/10ps
`include "gauge_cmd_defines.vh"
module smbus_host_model (
  // clock
  input  logic clk,
  // bus wires, open drain with pull-up
  input  logic sda_w,
  output logic scl_m,
  output logic sda_m
);
  logic ok;
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    ok    = 1'b1;
  end
  // one bit: data set while clock low, sampled mid-high
  task bitx(input logic b, output logic r);
    sda_m <= b;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    repeat (4) @(posedge clk);
    r = sda_w;
    repeat (4) @(posedge clk);
    scl_m <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // start or repeated start; clock idles high outside frames
  task start;
    sda_m <= 1'b1;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    repeat (8) @(posedge clk);
    sda_m <= 1'b0;
    repeat (8) @(posedge clk);
    scl_m <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task stop;
    sda_m <= 1'b0;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    repeat (8) @(posedge clk);
    sda_m <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    if (r) ok = 1'b0; // slave left ack line high
  endtask
  // master acks the low byte and nacks the last one
  task rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  // write word; also how the host re-silences alarms
  task wr_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
    ok = 1'b1;
    start;
    wbyte({a, 1'b0});
    wbyte(c);
    wbyte(d[7:0]);
    wbyte(d[15:8]);
    stop;
  endtask
  task rd_word(input logic [7:0] c, output logic [15:0] v);
    ok = 1'b1;
    start;
    wbyte({`SLAVE_ADDR, 1'b0});
    wbyte(c);
    start;
    wbyte({`SLAVE_ADDR, 1'b1});
    rbyte(1'b0, v[7:0]);
    rbyte(1'b1, v[15:8]);
    stop;
  endtask
endmodule // smbus_host_model
